// [hdl/acxd_pkg.sv]
// Package for the ac excitation phase driver.
// Assumes a single 50 MHz clock domain and an active high async reset.
package acxd_pkg;

    // Phase levels while excitation is off
    localparam logic RST_PHASE_A = 1'b1;
    localparam logic RST_PHASE_B = 1'b0;

    // Non-overlap gap: one master clock period
    localparam int   GAP_CYCLES  = 1;
    localparam int   CNT_W       = 16;

    // Sequencer states, Gray coded along the cycle
    typedef enum logic [1:0] {
        ACXD_A_ON  = 2'b00,
        ACXD_GAP_B = 2'b01,
        ACXD_B_ON  = 2'b11,
        ACXD_GAP_A = 2'b10
    } acxd_state_t;

    // Four pin levels travel together
    typedef struct packed {
        logic phase_a;
        logic phase_a_n;
        logic phase_b;
        logic phase_b_n;
    } acxd_pins_t;

endpackage

// [hdl/acxd_sync.sv]
// Two-flop synchroniser for one level input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module acxd_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    always_comb
    begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end
endmodule

// [hdl/acxd_top.sv]
// Bridge excitation reversal phase driver, four registered outputs.
// Assumes enable and reverse request come from pins, so they are synchronised.
`timescale 1ns/1ps
module acxd_top
    import acxd_pkg::*;
#(
    // Gap length in master clock cycles, one or more
    parameter int GAP_LEN = GAP_CYCLES
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic ac_excitation_enable,
    input  wire logic reverse_req,
    // Bridge switch drive
    output logic      excite_phase_a,
    output logic      excite_phase_a_n,
    output logic      excite_phase_b,
    output logic      excite_phase_b_n
);
    // Gap timer limits, sized to the counter
    localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_LEN - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // Rest image while excitation is off
    localparam acxd_pins_t REST_PINS = '{RST_PHASE_A, ~RST_PHASE_A,
                                         RST_PHASE_B, ~RST_PHASE_B};

    // Synchronised pin levels
    logic             en_s;
    logic             rev_s;

    // Sequencer
    acxd_state_t      st_r;
    acxd_state_t      st_nxt;

    // Gap timer
    logic [CNT_W-1:0] gap_cnt_r;
    logic [CNT_W-1:0] gap_cnt_nxt;
    logic             in_gap;
    logic             gap_done;

    // Registered pin image
    acxd_pins_t       pins_r;
    acxd_pins_t       pins_nxt;

    // Both control pins are asynchronous to clk

    acxd_sync u_sync_en
    (
        .clk (clk),
        .rst (rst),
        .d   (ac_excitation_enable),
        .q   (en_s)
    );

    acxd_sync u_sync_rev
    (
        .clk (clk),
        .rst (rst),
        .d   (reverse_req),
        .q   (rev_s)
    );

    // gap timer
    // Counts cycles in either gap state, clears on leaving it
    always_comb
    begin
        in_gap   = (st_r == ACXD_GAP_B) || (st_r == ACXD_GAP_A);
        gap_done = (gap_cnt_r == GAP_LAST);
        if (in_gap && !gap_done)
            gap_cnt_nxt = gap_cnt_r + CNT_ONE;
        else
            gap_cnt_nxt = '0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            gap_cnt_r <= '0;
        else
            gap_cnt_r <= gap_cnt_nxt;
    end

    // phase sequencer
    // A request dropped mid gap still finishes the gap first
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            ACXD_A_ON:
            begin
                if (en_s && rev_s)
                    st_nxt = ACXD_GAP_B;
            end
            ACXD_GAP_B:
            begin
                if (gap_done)
                    st_nxt = ACXD_B_ON;
            end
            ACXD_B_ON:
            begin
                if (!en_s || !rev_s)
                    st_nxt = ACXD_GAP_A;
            end
            ACXD_GAP_A:
            begin
                if (gap_done)
                    st_nxt = ACXD_A_ON;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_r <= ACXD_A_ON;
        else
            st_r <= st_nxt;
    end

    // levels per state, never both high
    always_comb
    begin
        pins_nxt = REST_PINS;
        unique case (st_nxt)
            ACXD_A_ON:
            begin
                pins_nxt.phase_a = 1'h1;
                pins_nxt.phase_b = 1'h0;
            end
            ACXD_GAP_B:
            begin
                pins_nxt.phase_a = 1'h0;
                pins_nxt.phase_b = 1'h0;
            end
            ACXD_B_ON:
            begin
                pins_nxt.phase_a = 1'h0;
                pins_nxt.phase_b = 1'h1;
            end
            ACXD_GAP_A:
            begin
                pins_nxt.phase_a = 1'h0;
                pins_nxt.phase_b = 1'h0;
            end
        endcase
        // off and idle rests at normal
        if (!en_s && st_r == ACXD_A_ON)
        begin
            pins_nxt.phase_a = RST_PHASE_A;
            pins_nxt.phase_b = RST_PHASE_B;
        end
        pins_nxt.phase_a_n = ~pins_nxt.phase_a;
        pins_nxt.phase_b_n = ~pins_nxt.phase_b;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pins_r <= REST_PINS;
        else
            pins_r <= pins_nxt;
    end

    always_comb
    begin
        excite_phase_a   = pins_r.phase_a;
        excite_phase_a_n = pins_r.phase_a_n;
        excite_phase_b   = pins_r.phase_b;
        excite_phase_b_n = pins_r.phase_b_n;
    end
endmodule

// [test/acxd_bridge_model.sv]
// Bridge reversal switches driven by the four phase pins.
// Assumes pins arrive without delay; flags a supply short.
`timescale 1ns/1ps
module acxd_bridge_model
    import acxd_pkg::*;
(
    input  wire acxd_pins_t pins,
    output logic            shorted
);
    // Both pairs closed, or a split pair, shorts the supply
    assign shorted = (pins.phase_a & pins.phase_b)
        | (pins.phase_a ~^ pins.phase_a_n) | (pins.phase_b ~^ pins.phase_b_n);
endmodule

// [test/acxd_props.sv]
// Checker for the four phase pins of the driver.
// Assumes one clock domain and an async active high reset.
`timescale 1ns/1ps
module acxd_props
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control pins
    input  wire logic ac_excitation_enable,
    input  wire logic reverse_req,
    // Phase pins
    input  wire logic excite_phase_a,
    input  wire logic excite_phase_a_n,
    input  wire logic excite_phase_b,
    input  wire logic excite_phase_b_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Six cycles covers the two-flop path plus gap
    sequence s_off; !ac_excitation_enable[*6]; endsequence
    sequence s_rev; (ac_excitation_enable && reverse_req)[*6]; endsequence
    sequence s_nrm; (ac_excitation_enable && !reverse_req)[*6]; endsequence
    a_no_overlap:
    assert property (!(excite_phase_a && excite_phase_b)) else $error("both");
    a_b_inverse:
    assert property (excite_phase_b_n == !excite_phase_b) else $error("b_n");
    a_a_inverse:
    assert property (excite_phase_a_n == !excite_phase_a) else $error("a_n");
    a_gap_before_b:
    assert property ($rose(excite_phase_b) |-> !$past(excite_phase_a))
        else $error("gap b");
    a_gap_before_a:
    assert property ($rose(excite_phase_a) |-> !$past(excite_phase_b))
        else $error("gap a");
    a_gap_len_b:
    assert property ($fell(excite_phase_a) |=> excite_phase_b)
        else $error("gap length before b");
    a_gap_len_a:
    assert property ($fell(excite_phase_b) |=> excite_phase_a)
        else $error("gap length before a");
    a_off_rest:
    assert property (s_off |-> excite_phase_a && !excite_phase_b)
        else $error("rest");
    a_rev_hold:
    assert property (s_rev |-> !excite_phase_a && excite_phase_b)
        else $error("rev");
    a_nrm_hold:
    assert property (s_nrm |-> excite_phase_a && !excite_phase_b)
        else $error("nrm");
endmodule
bind acxd_top acxd_props u_props (.*);

// [test/tb.sv]
// Testbench: drives enable and reverse request, checks the pins.
// Assumes the bridge model only observes the pins.
`timescale 1ns/1ps
module tb;
    import acxd_pkg::*;
    // Pin images: a, a_n, b, b_n
    localparam acxd_pins_t REST = 4'h9;
    localparam acxd_pins_t GAP  = 4'h5;
    localparam acxd_pins_t REV  = 4'h6;
    logic            clk = 1'h0;
    logic            rst = 1'h1;
    logic            en  = 1'h0;
    logic            req = 1'h0;
    logic            shorted;
    // A net, as four port connections drive its members
    wire acxd_pins_t pins;
    int              num_errors = 0;
    int              n_compared = 0;
    initial forever #10 clk = ~clk;
    acxd_top uut (.clk(clk), .rst(rst), .ac_excitation_enable(en),
        .reverse_req(req), .excite_phase_a(pins.phase_a),
        .excite_phase_a_n(pins.phase_a_n), .excite_phase_b(pins.phase_b),
        .excite_phase_b_n(pins.phase_b_n));
    acxd_bridge_model sw (.pins(pins), .shorted(shorted));
    task automatic report_and_stop;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(acxd_pins_t exp);
        n_compared++;
        if (pins !== exp || shorted !== 1'b0)
        begin
            num_errors++;
            $display("Error %0t pins %b exp %b", $time, pins, exp);
        end
    endtask
    task automatic step;
        @(posedge clk) #1;
    endtask
    task automatic go(logic e, logic r);
        @(posedge clk);
        en <= e;
        req <= r;
    endtask
    // Bounded wait; a miss counts and ends the run
    task automatic seek(acxd_pins_t exp);
        for (int i = 0; i < 12 && pins !== exp; i++)
            step();
        cmp(exp);
        if (pins !== exp)
            report_and_stop();
    endtask
    task automatic test_refuse;
        go(1'h0, 1'h1);
        repeat (8) step();
        cmp(REST);
        $display("refuse done");
    endtask
    // Holds long enough for the checker's six-cycle windows
    task automatic test_reverse;
        go(1'h1, 1'h1);
        seek(GAP);
        step();
        cmp(REV);
        repeat (4) step();
        cmp(REV);
        $display("reverse done");
    endtask
    task automatic test_restore;
        go(1'h1, 1'h0);
        seek(GAP);
        step();
        cmp(REST);
        repeat (4) step();
        cmp(REST);
        $display("restore done");
    endtask
    task automatic test_disable;
        go(1'h1, 1'h1);
        seek(REV);
        go(1'h0, 1'h1);
        seek(GAP);
        step();
        cmp(REST);
        repeat (4) step();
        cmp(REST);
        $display("disable done");
    endtask
    // Reset mid reversal, then restart through the synchronisers
    task automatic test_reset_mid;
        go(1'h1, 1'h1);
        seek(REV);
        @(posedge clk);
        rst <= 1'h1;
        step();
        cmp(REST);
        @(posedge clk);
        rst <= 1'h0;
        step();
        cmp(REST);
        step();
        cmp(REST);
        seek(GAP);
        step();
        cmp(REV);
        $display("reset done");
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        test_refuse();
        test_reverse();
        test_restore();
        test_disable();
        test_reset_mid();
        report_and_stop();
    end
endmodule
